// *** cli_pkg.sv ***
// package for the character display instruction decoder: encodings, reset values, cycle counts
// assumes one system clock standing in for the display oscillator
package cli_pkg;
  localparam logic [7:0] CLI_OP_NOP = 8'h00;
  localparam logic [7:0] CLI_OP_CLEAR = 8'h01;
  localparam logic [7:0] CLI_SPACE_CODE = 8'h20;
  localparam logic [6:0] CLI_ADDR_ZERO = 7'h00;
  localparam logic [6:0] CLI_RAM_DEPTH = 7'h7f;
  localparam int CLI_CYC_CLEAR = 165;
  localparam int CLI_CYC_STD = 3;
  localparam int CLI_CYC_W = 8;
  localparam logic [1:0] CLI_LINES_RESET = 2'h0;
  localparam logic [1:0] CLI_LINES_2X24 = 2'h1;
  localparam logic [1:0] CLI_LINES_4X12 = 2'h3;
  localparam logic [1:0] CLI_MUX_16 = 2'h1;
  localparam logic [1:0] CLI_MUX_32 = 2'h2;
  localparam int CLI_BIT_CO = 7;
  localparam int CLI_BIT_RS = 6;
  localparam int CLI_BIT_RW = 5;
  typedef enum logic [1:0] {CLI_ST_INIT, CLI_ST_IDLE, CLI_ST_BUSY} cli_state_t;
  typedef enum logic [1:0] {CLI_I2C_CTRL, CLI_I2C_DATA, CLI_I2C_PAIR} cli_i2c_t;
endpackage : cli_pkg

// *** cli_decoder.sv ***
// instruction interpreter of a character display controller
// assumes host strobes come from a bus front end on clk_sys; data bytes already assembled
//
// Function
// - line mode 0,1 gives two lines of 24 at 1:32, right half mirrored
// - line mode 1,1 gives four lines of 12 at 1:32
// - initialization runs by itself after reset without host instructions
// - after init: display cleared, 8-bit, one line, all off, increment, no shift
// - only an instruction register and a data register face the host
// - while busy only the busy and address read executes
// - busy flag high during execution; host polls it or waits
// - address counter steps by one per ram transfer, per direction
// - with shift enabled a display write also shifts the display
// - clear blanks display ram, address zero, 165 cycles
// - home sets address zero and undoes shift, 3 cycles
// - entry mode latches direction and shift enable, 3 cycles
// - display control latches display, cursor and blink, 3 cycles
// - shift instruction moves cursor or display left or right
// - function set latches width, line mode and generator, 3 cycles
// - pattern address loads six low address bits, selects pattern ram
// - display address loads seven bits, selects display ram
// - busy and address read returns flag and counter, no cycles
// - data read returns byte at current address, 3 cycles
// - data write stores byte at current address, 3 cycles
// - over i2c the width bit is ignored, always 8-bit
// - i2c control byte carries continuation, select and read/write bits
// - continuation 0 means only data follows, 1 means data then control
`timescale 1ns/10ps
module cli_decoder
  import cli_pkg::*;
#(
  parameter int CYC_CLEAR = CLI_CYC_CLEAR,
  parameter int CYC_STD = CLI_CYC_STD
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic host_wr_stb,
  input wire logic host_rd_stb,
  input wire logic register_select,
  input wire logic [7:0] host_data_lines,
  input wire logic i2c_mode,
  input wire logic i2c_byte_stb,
  input wire logic [7:0] i2c_byte,
  output logic [7:0] host_rdata,
  output logic busy_flag,
  output logic [6:0] address_counter,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic entry_increment,
  output logic entry_shift,
  output logic bus_width_select,
  output logic [1:0] line_mode,
  output logic vgen_sel,
  output logic [1:0] mux_ratio,
  output logic mirror_right,
  output logic [6:0] display_offset
);
  cli_state_t state_reg, state_next;
  cli_i2c_t i2c_reg;
  logic [7:0] instruction_reg;
  logic [7:0] data_reg;
  logic [7:0] display_ram [0:127];
  logic [7:0] pattern_ram [0:127];
  logic sel_pattern_reg;
  logic i2c_rs_reg;
  logic [CLI_CYC_W-1:0] cnt_reg;
  logic [6:0] clr_addr_reg;
  logic busy_reg;
  logic [6:0] ac_reg;
  logic [7:0] rd_reg;

  // one step up or down, wrapping inside the 7-bit address space
  function automatic logic [6:0] cli_step(input logic [6:0] v, input logic up);
    return up ? v + 7'h01 : v - 7'h01;
  endfunction : cli_step

  // i2c: control bytes retarget select; data bytes become writes
  wire i2c_is_ctrl = i2c_mode && i2c_byte_stb && (i2c_reg == CLI_I2C_CTRL);
  wire i2c_is_data = i2c_mode && i2c_byte_stb && (i2c_reg != CLI_I2C_CTRL);
  wire cmd_stb = i2c_mode ? i2c_is_data : host_wr_stb;
  wire cmd_rs = i2c_mode ? i2c_rs_reg : register_select;
  wire [7:0] cmd_byte = i2c_mode ? i2c_byte : host_data_lines;
  wire idle = (state_reg == CLI_ST_IDLE);
  wire accept = cmd_stb && idle;
  wire is_nop = !cmd_rs && (cmd_byte == CLI_OP_NOP);
  wire is_instr = accept && !cmd_rs && !is_nop;
  wire is_wdata = accept && cmd_rs;
  wire rd_data = host_rd_stb && register_select && idle && !i2c_mode;
  wire op_clear = is_instr && (cmd_byte == CLI_OP_CLEAR);
  wire op_home = is_instr && (cmd_byte[7:1] == 7'h01);
  wire op_entry = is_instr && (cmd_byte[7:2] == 6'h01);
  wire op_dctl = is_instr && (cmd_byte[7:3] == 5'h01);
  wire op_shift = is_instr && (cmd_byte[7:4] == 4'h1) && (cmd_byte[1:0] == 2'h0);
  wire op_func = is_instr && (cmd_byte[7:5] == 3'h1) && !cmd_byte[0];
  wire op_cgadr = is_instr && (cmd_byte[7:6] == 2'h1);
  wire op_ddadr = is_instr && cmd_byte[7];
  wire clearing = (state_reg == CLI_ST_INIT) || ((state_reg == CLI_ST_BUSY) && (clr_addr_reg != CLI_ADDR_ZERO));
  wire [6:0] ac_step = cli_step(ac_reg, entry_increment);
  wire ram_xfer = is_wdata || rd_data;
  wire [CLI_CYC_W-1:0] cyc_load = op_clear ? CYC_CLEAR[CLI_CYC_W-1:0] : CYC_STD[CLI_CYC_W-1:0];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) i2c_reg <= CLI_I2C_CTRL;
    else if (!i2c_mode) i2c_reg <= CLI_I2C_CTRL;
    else if (i2c_is_ctrl) i2c_reg <= i2c_byte[CLI_BIT_CO] ? CLI_I2C_PAIR : CLI_I2C_DATA;
    else if (i2c_is_data && i2c_reg == CLI_I2C_PAIR) i2c_reg <= CLI_I2C_CTRL;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) i2c_rs_reg <= 1'b0;
    else if (i2c_is_ctrl) i2c_rs_reg <= i2c_byte[CLI_BIT_RS];
  end

  // state sequence: init walks the ram, then busy; idle goes busy on any instruction but nop, or on a ram transfer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CLI_ST_INIT: if (clr_addr_reg == CLI_RAM_DEPTH) state_next = CLI_ST_BUSY;
      CLI_ST_IDLE: if (is_instr || is_wdata || rd_data) state_next = CLI_ST_BUSY;
      CLI_ST_BUSY: if (cnt_reg <= 8'h01) state_next = CLI_ST_IDLE;
      default: state_next = CLI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) state_reg <= CLI_ST_INIT;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) cnt_reg <= '0;
    else if (state_reg == CLI_ST_INIT) cnt_reg <= CYC_STD[CLI_CYC_W-1:0];
    else if (state_next == CLI_ST_BUSY && idle) cnt_reg <= cyc_load;
    else if (cnt_reg != '0) cnt_reg <= cnt_reg - 8'h01;
  end

  // clear walks display ram one word per cycle; 128 words fit inside 165 cycles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) clr_addr_reg <= CLI_ADDR_ZERO;
    else if (op_clear) clr_addr_reg <= 7'h01;
    else if (clearing) clr_addr_reg <= clr_addr_reg + 7'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (op_clear) display_ram[CLI_ADDR_ZERO] <= CLI_SPACE_CODE;
    else if (clearing) display_ram[clr_addr_reg] <= CLI_SPACE_CODE;
    else if (is_wdata && !sel_pattern_reg) display_ram[ac_reg] <= cmd_byte;
    if (is_wdata && sel_pattern_reg) pattern_ram[ac_reg] <= cmd_byte;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) instruction_reg <= CLI_OP_NOP;
    else if (is_instr) instruction_reg <= cmd_byte;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) data_reg <= CLI_OP_NOP;
    else if (is_wdata) data_reg <= cmd_byte;
    else if (rd_data) data_reg <= sel_pattern_reg ? pattern_ram[ac_reg] : display_ram[ac_reg];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) ac_reg <= CLI_ADDR_ZERO;
    else if (op_clear || op_home) ac_reg <= CLI_ADDR_ZERO;
    else if (op_cgadr) ac_reg <= {ac_reg[6], cmd_byte[5:0]};
    else if (op_ddadr) ac_reg <= cmd_byte[6:0];
    else if (op_shift && !cmd_byte[3]) ac_reg <= cli_step(ac_reg, cmd_byte[2]);
    else if (ram_xfer) ac_reg <= ac_step;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) sel_pattern_reg <= 1'b0;
    else if (op_cgadr) sel_pattern_reg <= 1'b1;
    else if (op_ddadr || op_clear) sel_pattern_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) display_offset <= CLI_ADDR_ZERO;
    else if (op_clear || op_home) display_offset <= CLI_ADDR_ZERO;
    else if (op_shift && cmd_byte[3]) display_offset <= cli_step(display_offset, cmd_byte[2]);
    else if (is_wdata && !sel_pattern_reg && entry_shift)
      display_offset <= cli_step(display_offset, !entry_increment);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      entry_increment <= 1'b1;
      entry_shift <= 1'b0;
    end else if (op_clear) begin
      entry_increment <= 1'b1;
    end else if (op_entry) begin
      entry_increment <= cmd_byte[1];
      entry_shift <= cmd_byte[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      display_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
    end else if (op_dctl) begin
      display_on <= cmd_byte[2];
      cursor_on <= cmd_byte[1];
      blink_on <= cmd_byte[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_width_select <= 1'b1;
      line_mode <= CLI_LINES_RESET;
      vgen_sel <= 1'b0;
    end else if (op_func) begin
      bus_width_select <= i2c_mode ? 1'b1 : cmd_byte[4];
      line_mode <= cmd_byte[3:2];
      vgen_sel <= cmd_byte[1];
    end
  end

  // multiplex and mirroring follow the latched line mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mux_ratio <= CLI_MUX_16;
      mirror_right <= 1'b0;
    end else begin
      mux_ratio <= (line_mode == CLI_LINES_2X24 || line_mode == CLI_LINES_4X12) ? CLI_MUX_32 : CLI_MUX_16;
      mirror_right <= (line_mode == CLI_LINES_2X24);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) busy_reg <= 1'b1;
    else busy_reg <= (state_next != CLI_ST_IDLE);
  end

  // status read answers even while busy; data read returns the ram byte at the current address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rd_reg <= CLI_OP_NOP;
    else if (host_rd_stb && !register_select) rd_reg <= {busy_reg, ac_reg};
    else if (rd_data) rd_reg <= sel_pattern_reg ? pattern_ram[ac_reg] : display_ram[ac_reg];
  end

  assign host_rdata = rd_reg;
  assign busy_flag = busy_reg;
  assign address_counter = ac_reg;

  a_busy_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
    busy_flag && host_wr_stb && !i2c_mode |=> $stable(instruction_reg) && $stable(data_reg))
    else $error("instruction taken while busy");
  a_clear_len: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_clear |=> busy_flag [*8]) else $error("clear busy too short");
  a_std_len: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_dctl |=> busy_flag ##1 busy_flag ##1 busy_flag ##1 !busy_flag) else $error("3 cycle op wrong");
  a_nop_free: assert property (@(posedge clk_sys) disable iff (!rstn)
    idle && cmd_stb && is_nop && !rd_data |=> !busy_flag) else $error("nop made busy");
  a_ac_step: assert property (@(posedge clk_sys) disable iff (!rstn)
    is_wdata && entry_increment |=> ac_reg == $past(ac_reg) + 7'h01) else $error("address not stepped");
  a_home_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_home |=> ac_reg == CLI_ADDR_ZERO && display_offset == CLI_ADDR_ZERO) else $error("home failed");
  a_cg_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_cgadr |=> ac_reg[5:0] == $past(cmd_byte[5:0]) && ac_reg[6] == $past(ac_reg[6])) else $error("pattern addr");
  a_dd_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_ddadr |=> ac_reg == $past(cmd_byte[6:0])) else $error("display addr wrong");
  a_status_rd: assert property (@(posedge clk_sys) disable iff (!rstn)
    host_rd_stb && !register_select |=> host_rdata == {$past(busy_reg), $past(ac_reg)}) else $error("status read");
  a_i2c_width: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_func && i2c_mode |=> bus_width_select) else $error("width changed over i2c");
  a_four_line: assert property (@(posedge clk_sys) disable iff (!rstn)
    line_mode == CLI_LINES_4X12 |=> mux_ratio == CLI_MUX_32 && !mirror_right) else $error("4 line mode");

  // latched state follows the instruction bits one cycle after acceptance
  a_entry_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_entry |=> entry_increment == $past(cmd_byte[1]) && entry_shift == $past(cmd_byte[0]))
    else $error("entry mode not latched");
  a_dctl_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_dctl |=> display_on == $past(cmd_byte[2]) && cursor_on == $past(cmd_byte[1]) && blink_on == $past(cmd_byte[0]))
    else $error("display control not latched");
  a_func_lines: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_func |=> line_mode == $past(cmd_byte[3:2]) && vgen_sel == $past(cmd_byte[1]))
    else $error("function set lines wrong");
  a_func_width: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_func && !i2c_mode |=> bus_width_select == $past(cmd_byte[4]))
    else $error("function set width wrong");
  a_two_line: assert property (@(posedge clk_sys) disable iff (!rstn)
    line_mode == CLI_LINES_2X24 |=> mux_ratio == CLI_MUX_32 && mirror_right)
    else $error("2 line mode wrong");
  a_clear_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_clear |=> ac_reg == CLI_ADDR_ZERO && display_offset == CLI_ADDR_ZERO && entry_increment)
    else $error("clear state wrong");
  a_clear_end: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_clear |-> ##165 busy_flag ##1 !busy_flag)
    else $error("clear length wrong");

  // ram transfers cost the standard three cycles and step the counter
  a_rd_len: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_data |=> busy_flag ##1 busy_flag ##1 busy_flag ##1 !busy_flag)
    else $error("read length wrong");
  a_wr_len: assert property (@(posedge clk_sys) disable iff (!rstn)
    is_wdata |=> busy_flag ##1 busy_flag ##1 busy_flag ##1 !busy_flag)
    else $error("write length wrong");
  a_rd_step: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_data && !entry_increment |=> ac_reg == $past(ac_reg) - 7'h01)
    else $error("address not stepped down");
  a_wr_shift: assert property (@(posedge clk_sys) disable iff (!rstn)
    is_wdata && !sel_pattern_reg && entry_shift && entry_increment |=> display_offset == $past(display_offset) - 7'h01)
    else $error("display not shifted on write");

  // busy covers every non-idle state and freezes the visible state
  a_busy_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    busy_flag == (state_reg != CLI_ST_IDLE))
    else $error("busy flag out of step");
  a_busy_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    !idle |=> $stable(ac_reg) && $stable(data_reg))
    else $error("state changed while busy");
  a_status_free: assert property (@(posedge clk_sys) disable iff (!rstn)
    host_rd_stb && !register_select && idle && !cmd_stb |=> !busy_flag)
    else $error("status read made busy");
  a_nop_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
    accept && is_nop |=> $stable(ac_reg) && $stable(display_offset))
    else $error("nop changed state");
  a_dd_select: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_ddadr |=> !sel_pattern_reg)
    else $error("display ram not selected");
  a_cg_select: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_cgadr |=> sel_pattern_reg)
    else $error("pattern ram not selected");
  a_cursor_move: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_shift && !cmd_byte[3] |=> display_offset == $past(display_offset))
    else $error("cursor move shifted display");
  a_disp_move: assert property (@(posedge clk_sys) disable iff (!rstn)
    op_shift && cmd_byte[3] |=> ac_reg == $past(ac_reg))
    else $error("display shift moved address");

  // i2c byte parsing
  a_i2c_ctrl_rs: assert property (@(posedge clk_sys) disable iff (!rstn)
    i2c_is_ctrl |=> i2c_rs_reg == $past(i2c_byte[CLI_BIT_RS]))
    else $error("control byte select lost");
  a_i2c_pair: assert property (@(posedge clk_sys) disable iff (!rstn)
    i2c_is_data && i2c_reg == CLI_I2C_PAIR |=> i2c_reg == CLI_I2C_CTRL)
    else $error("no control byte after pair");

  c_clear: cover property (@(posedge clk_sys) disable iff (!rstn) op_clear ##[1:200] !busy_flag);
  c_i2c_func: cover property (@(posedge clk_sys) disable iff (!rstn) op_func && i2c_mode);
  c_status_busy: cover property (@(posedge clk_sys) disable iff (!rstn) host_rd_stb && !register_select && busy_flag);
  c_write: cover property (@(posedge clk_sys) disable iff (!rstn) is_wdata && entry_shift);
  c_i2c_pair: cover property (@(posedge clk_sys) disable iff (!rstn) i2c_is_ctrl && i2c_byte[CLI_BIT_CO]);
endmodule : cli_decoder

// *** cli_host.sv ***
// host model: sends parallel and i2c bytes, reads back, polls busy
// assumes clk_sys from the bench; every line changes on a falling edge
`timescale 1ns/10ps
module cli_host (
  input wire logic clk_sys,
  input wire logic busy_flag,
  output logic host_wr_stb,
  output logic host_rd_stb,
  output logic register_select,
  output logic [7:0] host_data_lines,
  output logic i2c_mode,
  output logic i2c_byte_stb,
  output logic [7:0] i2c_byte
);
  initial begin
    {host_wr_stb, host_rd_stb, register_select, i2c_mode, i2c_byte_stb} = 5'h00;
    host_data_lines = 8'h00;
    i2c_byte = 8'h00;
  end
  // released byte lines show the inverse, so a stale byte never passes for a fresh one
  task automatic wr(input logic rs, input logic [7:0] b);
    @(negedge clk_sys);
    register_select = rs;
    host_data_lines = b;
    host_wr_stb = 1'b1;
    @(negedge clk_sys);
    host_wr_stb = 1'b0;
    host_data_lines = ~b;
  endtask : wr
  task automatic rd(input logic rs);
    @(negedge clk_sys);
    register_select = rs;
    host_rd_stb = 1'b1;
    @(negedge clk_sys);
    host_rd_stb = 1'b0;
  endtask : rd
  // counts busy cycles; a count of 400 means the device hung
  task automatic idle(output int n);
    n = 0;
    while (busy_flag !== 1'b0 && n < 400) begin
      n++;
      @(negedge clk_sys);
    end
  endtask : idle
  task automatic mode(input logic m);
    @(negedge clk_sys);
    i2c_mode = m;
  endtask : mode
  task automatic i2c(input logic [7:0] b);
    @(negedge clk_sys);
    i2c_byte = b;
    i2c_byte_stb = 1'b1;
    @(negedge clk_sys);
    i2c_byte_stb = 1'b0;
    i2c_byte = ~b;
  endtask : i2c
  task automatic ctrl(input logic co, input logic rs);
    i2c({co, rs, 6'h00});
  endtask : ctrl
endmodule : cli_host

// *** cli_decoder_tb.sv ***
// self-checking bench for the instruction decoder, host model on its inputs
// assumes the decoder and host model compile first; reset held 3 cycles
`timescale 1ns/10ps
module cli_decoder_tb;
  import cli_pkg::*;
  logic clk_sys, rstn, host_wr_stb, host_rd_stb, register_select, i2c_mode, i2c_byte_stb;
  logic busy_flag, display_on, cursor_on, blink_on, entry_increment, entry_shift;
  logic bus_width_select, vgen_sel, mirror_right;
  logic [7:0] host_data_lines, i2c_byte, host_rdata;
  logic [6:0] address_counter, display_offset;
  logic [1:0] line_mode, mux_ratio;
  int err_total = 0;
  int n_tests = 0;
  cli_decoder i_cli_decoder (.clk_sys(clk_sys), .rstn(rstn), .host_wr_stb(host_wr_stb),
    .host_rd_stb(host_rd_stb), .register_select(register_select), .host_data_lines(host_data_lines),
    .i2c_mode(i2c_mode), .i2c_byte_stb(i2c_byte_stb), .i2c_byte(i2c_byte), .host_rdata(host_rdata),
    .busy_flag(busy_flag), .address_counter(address_counter), .display_on(display_on),
    .cursor_on(cursor_on), .blink_on(blink_on), .entry_increment(entry_increment),
    .entry_shift(entry_shift), .bus_width_select(bus_width_select), .line_mode(line_mode),
    .vgen_sel(vgen_sel), .mux_ratio(mux_ratio), .mirror_right(mirror_right),
    .display_offset(display_offset));
  cli_host i_cli_host (.clk_sys(clk_sys), .busy_flag(busy_flag), .host_wr_stb(host_wr_stb),
    .host_rd_stb(host_rd_stb), .register_select(register_select), .host_data_lines(host_data_lines),
    .i2c_mode(i2c_mode), .i2c_byte_stb(i2c_byte_stb), .i2c_byte(i2c_byte));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic chkn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chkn
  // exp below zero only guards against a hang
  task automatic go(input int exp);
    int n;
    i_cli_host.idle(n);
    if (n >= 400) begin
      err_total++;
      print_verdict();
    end
    if (exp >= 0) chkn(n, exp);
  endtask : go
  task automatic cmd(input logic rs, input logic [7:0] b, input int cyc);
    i_cli_host.wr(rs, b);
    go(cyc);
  endtask : cmd
  task automatic rdd();
    i_cli_host.rd(1'b1);
    go(3);
  endtask : rdd
  task automatic t_reset();
    go(-1);
    chk(8'({display_on, cursor_on, blink_on, entry_increment, entry_shift}), 8'h02);
    chk(8'({bus_width_select, line_mode, vgen_sel}), 8'h08);
    i_cli_host.rd(1'b0);
    chk(host_rdata, 8'h00);
    rdd();
    chk(host_rdata, CLI_SPACE_CODE);
    chk(8'(address_counter), 8'h01);
    $display("test reset done");
  endtask : t_reset
  task automatic t_setup();
    cmd(1'b0, CLI_OP_NOP, 0);
    cmd(1'b0, 8'h34, 3);
    chk(8'({line_mode, mux_ratio, mirror_right}), 8'({CLI_LINES_2X24, CLI_MUX_32, 1'b1}));
    cmd(1'b0, 8'h3e, 3);
    chk(8'({bus_width_select, line_mode, vgen_sel, mux_ratio, mirror_right}), 8'h7c);
    cmd(1'b0, 8'h0f, 3);
    chk(8'({display_on, cursor_on, blink_on}), 8'h07);
    cmd(1'b0, 8'h0a, 3);
    chk(8'({display_on, cursor_on, blink_on}), 8'h02);
    cmd(1'b0, 8'h07, 3);
    chk(8'({entry_increment, entry_shift}), 8'h03);
    $display("test setup done");
  endtask : t_setup
  task automatic t_ram();
    cmd(1'b0, 8'h85, 3);
    chk(8'(address_counter), 8'h05);
    i_cli_host.wr(1'b1, 8'h41);
    i_cli_host.wr(1'b1, 8'h42);
    go(1);
    chk(8'(address_counter), 8'h06);
    chk(8'(display_offset != 7'h00), 8'h01);
    i_cli_host.wr(1'b1, 8'h43);
    i_cli_host.rd(1'b0);
    chk(host_rdata, 8'h87);
    go(1);
    cmd(1'b0, 8'h04, 3);
    cmd(1'b0, 8'h86, 3);
    rdd();
    chk(host_rdata, 8'h43);
    chk(8'(address_counter), 8'h05);
    cmd(1'b0, 8'h14, 3);
    chk(8'(address_counter), 8'h06);
    cmd(1'b0, 8'h1c, 3);
    chk(8'(address_counter), 8'h06);
    cmd(1'b0, 8'h02, 3);
    chk(8'({address_counter, display_offset == 7'h00}), 8'h01);
    cmd(1'b0, 8'h7f, 3);
    chk(8'(address_counter), 8'h3f);
    cmd(1'b0, CLI_OP_CLEAR, 165);
    chk(8'({address_counter, entry_increment}), 8'h01);
    cmd(1'b0, 8'h86, 3);
    rdd();
    chk(host_rdata, CLI_SPACE_CODE);
    $display("test ram done");
  endtask : t_ram
  task automatic t_i2c();
    i_cli_host.mode(1'b1);
    i_cli_host.ctrl(1'b1, 1'b0);
    i_cli_host.i2c(8'h90);
    go(3);
    chk(8'(address_counter), 8'h10);
    i_cli_host.ctrl(1'b0, 1'b1);
    i_cli_host.i2c(8'h42);
    go(3);
    i_cli_host.i2c(8'h43);
    go(3);
    chk(8'(address_counter), 8'h12);
    i_cli_host.mode(1'b0);
    cmd(1'b0, 8'h91, 3);
    rdd();
    chk(host_rdata, 8'h43);
    i_cli_host.mode(1'b1);
    i_cli_host.ctrl(1'b1, 1'b0);
    i_cli_host.i2c(8'h20);
    go(3);
    chk(8'({bus_width_select, line_mode}), 8'h04);
    i_cli_host.mode(1'b0);
    $display("test i2c done");
  endtask : t_i2c
  initial begin
    rstn = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_setup();
    t_ram();
    t_i2c();
    print_verdict();
  end
endmodule : cli_decoder_tb
